// *** core/rx_framer_pkg.sv ***
package rx_framer_pkg;
  // ==========================================
  // Register offsets
  localparam logic [5:0] OFF_MARK_HI = 6'h04;
  localparam logic [5:0] OFF_MARK_LO = 6'h05;
  localparam logic [5:0] OFF_LIMIT   = 6'h06;
  localparam logic [5:0] OFF_CTRL_A  = 6'h07;
  localparam logic [5:0] OFF_CTRL_B  = 6'h08;
  localparam logic [5:0] OFF_NODE    = 6'h09;
  localparam logic [5:0] OFF_SLOT    = 6'h0a;
  localparam logic [5:0] OFF_IF      = 6'h0b;
  // ==========================================
  // Reset values and writable bits
  localparam logic [7:0] RST_MARK_HI = 8'hd3;
  localparam logic [7:0] RST_MARK_LO = 8'h91;
  localparam logic [7:0] RST_LIMIT   = 8'hff;
  localparam logic [7:0] RST_CTRL_A  = 8'h04;
  localparam logic [7:0] RST_CTRL_B  = 8'h45;
  localparam logic [7:0] RST_NODE    = 8'h00;
  localparam logic [7:0] RST_SLOT    = 8'h00;
  localparam logic [7:0] RST_IF      = 8'h0f;
  localparam logic [7:0] MASK_CTRL_A = 8'hef;
  localparam logic [7:0] MASK_CTRL_B = 8'h77;
  localparam logic [7:0] MASK_IF     = 8'h3f;
  // ==========================================
  // Field positions
  localparam int CA_DISCARD = 3;
  localparam int CA_TRAILER = 2;
  localparam int CB_CRC_EN  = 2;
  localparam int IF_SHIFT   = 6;
  // ==========================================
  // Encodings
  localparam logic [1:0] LEN_FIXED  = 2'h0;
  localparam logic [1:0] LEN_VAR    = 2'h1;
  localparam logic [1:0] LEN_INF    = 2'h2;
  localparam logic [1:0] PATH_FIFO  = 2'h0;
  localparam logic [1:0] PATH_SYNC  = 2'h1;
  localparam logic [1:0] PATH_ASYNC = 2'h3;
  localparam logic [1:0] FLT_OFF    = 2'h0;
  localparam logic [1:0] FLT_B0     = 2'h2;
  localparam logic [1:0] FLT_B0FF   = 2'h3;
  localparam logic [7:0] BCAST_LO   = 8'h00;
  localparam logic [7:0] BCAST_HI   = 8'hff;
  localparam logic [15:0] CRC_INIT  = 16'hffff;
  localparam logic [15:0] CRC_POLY  = 16'h8005;

  typedef enum logic [2:0] {
    S_HUNT = 3'h0,
    S_LEN  = 3'h1,
    S_ADR  = 3'h2,
    S_PAY  = 3'h3,
    S_CRC  = 3'h4,
    S_ST1  = 3'h5,
    S_ST2  = 3'h6
  } state_t;

  function automatic logic addr_accept(input logic [1:0] mode, input logic [7:0] a,
                                       input logic [7:0] node);
    addr_accept = (mode == FLT_OFF) || (a == node) ||
                  (mode == FLT_B0 && a == BCAST_LO) ||
                  (mode == FLT_B0FF && (a == BCAST_LO || a == BCAST_HI));
  endfunction
endpackage

// *** core/checksum_serial.sv ***
`timescale 1ns/1ns
module checksum_serial
  import rx_framer_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_core_n,
  // Bit stream
  input  wire logic        clear,
  input  wire logic        bit_en,
  input  wire logic        bit_in,
  // Result
  output logic             next_zero
);
  logic [15:0] crc;
  logic [15:0] next_crc;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CRC_POLY : 16'h0000);
  endfunction

  always_comb begin
    next_crc = crc;
    if (clear) begin
      next_crc = CRC_INIT;
    end else if (bit_en) begin
      next_crc = crc_step(crc, bit_in);
    end
  end

  // Zero after the last checksum bit means the packet is good
  assign next_zero = (crc_step(crc, bit_in) == 16'h0000);

  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      crc <= CRC_INIT;
    end else begin
      crc <= next_crc;
    end
  end
endmodule

// *** core/two_entry_buffer.sv ***
`timescale 1ns/1ns
module two_entry_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_core_n,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem      [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic [PW-1:0]    next_wr_ptr;
  logic [PW-1:0]    next_rd_ptr;
  logic [CW-1:0]    next_count;
  logic             push;
  logic             pop;

  function automatic logic [PW-1:0] wrap_inc(input logic [PW-1:0] p);
    wrap_inc = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign in_ready  = (count != CW'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_mem    = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (push) begin
      next_mem[wr_ptr] = in_data;
      next_wr_ptr      = wrap_inc(wr_ptr);
    end
    if (pop) begin
      next_rd_ptr = wrap_inc(rd_ptr);
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
      mem    <= next_mem;
    end
  end

  a_buf_stall: assert property (@(posedge core_clk) disable iff (!rst_core_n)
    (!in_ready && !out_ready) |=> !in_ready && out_data == $past(out_data))
    else $error("buffer lost a word while stalled");
endmodule

// *** core/rx_packet_handler.sv ***
// What this block does
// - Detect the 16-bit marker from two registers, reset 0xd3 and 0x91.
// - Fixed length mode: every packet is exactly the size limit, reset 255.
// - Variable length mode: the size limit is the largest length accepted.
// - With discard set, a failed checksum flushes the receive FIFO.
// - With trailer enabled, append RSSI and checksum-good bytes after payload.
// - Filter mode: 00 none, 01 own, 10 plus 0x00, 11 plus 0x00 and 0xff.
// - Output path: 00 FIFO, 01 synchronous serial pin, 11 asynchronous serial pin.
// - Size mode: 00 fixed, 01 length from first byte, 10 infinite.
// - Compare received address with own node id, broadcasts if enabled.
// - Add slot index times channel spacing to the base frequency.
// - In receive subtract intermediate code times crystal over 1024; feed mixer.
`timescale 1ns/1ns
module rx_packet_handler
  import rx_framer_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [5:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic [7:0]       reg_rdata,
  // Demodulated bits
  input  wire logic        rx_bit,
  input  wire logic        rx_bit_valid,
  output logic             rx_bit_ready,
  input  wire logic [7:0]  rssi,
  input  wire logic [6:0]  link_quality,
  // Receive FIFO side
  output logic [7:0]       fifo_data,
  output logic             fifo_valid,
  input  wire logic        fifo_ready,
  output logic             rx_flush,
  // Serial output pins
  output logic [1:0]       general_output_pins,
  // Synthesizer
  input  wire logic        rx_mode,
  input  wire logic [23:0] base_freq,
  input  wire logic [15:0] rf_slot_index_spacing,
  output logic [23:0]      synth_word,
  output logic [4:0]       mixer_if_code
);
  // ==========================================
  // Reset release
  logic rst_meta_n;
  logic rst_core_n;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_core_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_core_n <= rst_meta_n;
    end
  end

  // ==========================================
  // Registers
  logic [7:0] mark_hi, mark_lo, limit, ctrl_a, ctrl_b, node, slot, if_ctl;
  logic [7:0] next_mark_hi, next_mark_lo, next_limit, next_ctrl_a;
  logic [7:0] next_ctrl_b, next_node, next_slot, next_if_ctl, next_rdata;

  logic       discard;
  logic       trailer;
  logic [1:0] filter;
  logic [1:0] path;
  logic       crc_en;
  logic [1:0] size;

  assign discard = ctrl_a[CA_DISCARD];
  assign trailer = ctrl_a[CA_TRAILER];
  assign filter  = ctrl_a[1:0];
  assign path    = ctrl_b[5:4];
  assign crc_en  = ctrl_b[CB_CRC_EN];
  assign size    = ctrl_b[1:0];

  always_comb begin
    next_mark_hi = mark_hi;
    next_mark_lo = mark_lo;
    next_limit   = limit;
    next_ctrl_a  = ctrl_a;
    next_ctrl_b  = ctrl_b;
    next_node    = node;
    next_slot    = slot;
    next_if_ctl  = if_ctl;
    next_rdata   = reg_rdata;
    if (reg_wr) begin
      case (reg_addr)
        OFF_MARK_HI: next_mark_hi = reg_wdata;
        OFF_MARK_LO: next_mark_lo = reg_wdata;
        OFF_LIMIT:   next_limit   = reg_wdata;
        OFF_CTRL_A:  next_ctrl_a  = reg_wdata & MASK_CTRL_A;
        OFF_CTRL_B:  next_ctrl_b  = reg_wdata & MASK_CTRL_B;
        OFF_NODE:    next_node    = reg_wdata;
        OFF_SLOT:    next_slot    = reg_wdata;
        OFF_IF:      next_if_ctl  = reg_wdata & MASK_IF;
        default:     next_node    = node;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        OFF_MARK_HI: next_rdata = mark_hi;
        OFF_MARK_LO: next_rdata = mark_lo;
        OFF_LIMIT:   next_rdata = limit;
        OFF_CTRL_A:  next_rdata = ctrl_a;
        OFF_CTRL_B:  next_rdata = ctrl_b;
        OFF_NODE:    next_rdata = node;
        OFF_SLOT:    next_rdata = slot;
        OFF_IF:      next_rdata = if_ctl;
        default:     next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      mark_hi   <= RST_MARK_HI;
      mark_lo   <= RST_MARK_LO;
      limit     <= RST_LIMIT;
      ctrl_a    <= RST_CTRL_A;
      ctrl_b    <= RST_CTRL_B;
      node      <= RST_NODE;
      slot      <= RST_SLOT;
      if_ctl    <= RST_IF;
      reg_rdata <= 8'h00;
    end else begin
      mark_hi   <= next_mark_hi;
      mark_lo   <= next_mark_lo;
      limit     <= next_limit;
      ctrl_a    <= next_ctrl_a;
      ctrl_b    <= next_ctrl_b;
      node      <= next_node;
      slot      <= next_slot;
      if_ctl    <= next_if_ctl;
      reg_rdata <= next_rdata;
    end
  end

  // ==========================================
  // Packet engine
  state_t      state, next_state;
  logic [14:0] shreg, next_shreg;
  logic [2:0]  bitcnt, next_bitcnt;
  logic [6:0]  sh, next_sh;
  logic [7:0]  remain, next_remain;
  logic        crc_ok, next_crc_ok;
  logic        next_flush;
  logic        crc_clear;
  logic        crc_zero;
  logic        in_data_state;
  logic        bit_take;
  logic        byte_done;
  logic [7:0]  byte_val;
  logic        buf_in_valid;
  logic        buf_in_ready;
  logic [7:0]  buf_in_data;

  // Next step once the payload has ended
  function automatic state_t after_payload(input logic c_en, input logic trl);
    after_payload = c_en ? S_CRC : (trl ? S_ST1 : S_HUNT);
  endfunction

  assign in_data_state = (state == S_LEN) || (state == S_ADR) ||
                         (state == S_PAY) || (state == S_CRC);
  // Bits are held off while the buffer is full, so no byte is lost
  assign rx_bit_ready  = (path != PATH_FIFO) ||
                         (buf_in_ready && state != S_ST1 && state != S_ST2);
  assign bit_take      = rx_bit_valid && rx_bit_ready;
  assign byte_val      = {sh, rx_bit};
  assign byte_done     = bit_take && in_data_state && bitcnt == 3'h7;
  assign buf_in_valid  = (byte_done && state != S_CRC) ||
                         state == S_ST1 || state == S_ST2;
  assign buf_in_data   = (state == S_ST1) ? rssi :
                         (state == S_ST2) ? {crc_ok, link_quality} : byte_val;

  always_comb begin
    next_state  = state;
    next_shreg  = shreg;
    next_bitcnt = bitcnt;
    next_sh     = sh;
    next_remain = remain;
    next_crc_ok = crc_ok;
    next_flush  = 1'b0;
    crc_clear   = 1'b0;
    if (bit_take && in_data_state) begin
      next_bitcnt = bitcnt + 3'h1;
      next_sh     = byte_val[6:0];
    end
    case (state)
      S_HUNT: begin
        if (bit_take && path == PATH_FIFO) begin
          next_shreg = {shreg[13:0], rx_bit};
          if ({shreg, rx_bit} == {mark_hi, mark_lo}) begin
            next_shreg  = '0;
            next_bitcnt = 3'h0;
            next_remain = limit;
            next_crc_ok = 1'b0;
            crc_clear   = 1'b1;
            next_state  = (size == LEN_VAR) ? S_LEN :
                          (filter != FLT_OFF) ? S_ADR : S_PAY;
          end
        end
      end
      S_LEN: begin
        if (byte_done) begin
          if (byte_val == 8'h00 || byte_val > limit) begin
            next_flush = 1'b1;
            next_state = S_HUNT;
          end else begin
            next_remain = byte_val;
            next_state  = (filter != FLT_OFF) ? S_ADR : S_PAY;
          end
        end
      end
      S_ADR: begin
        if (byte_done) begin
          next_remain = remain - 8'h01;
          if (!addr_accept(filter, byte_val, node)) begin
            next_flush = 1'b1;
            next_state = S_HUNT;
          end else if (remain == 8'h01 && size != LEN_INF) begin
            next_remain = 8'h02;
            next_state  = after_payload(crc_en, trailer);
          end else begin
            next_state  = S_PAY;
          end
        end
      end
      S_PAY: begin
        if (byte_done && size != LEN_INF) begin
          next_remain = remain - 8'h01;
          if (remain == 8'h01) begin
            next_remain = 8'h02;
            next_state  = after_payload(crc_en, trailer);
          end
        end
      end
      S_CRC: begin
        if (byte_done) begin
          next_remain = remain - 8'h01;
          if (remain == 8'h01) begin
            next_crc_ok = crc_zero;
            if (!crc_zero && discard) begin
              next_flush = 1'b1;
              next_state = S_HUNT;
            end else begin
              next_state = trailer ? S_ST1 : S_HUNT;
            end
          end
        end
      end
      S_ST1: begin
        if (buf_in_ready) begin
          next_state = S_ST2;
        end
      end
      S_ST2: begin
        if (buf_in_ready) begin
          next_state = S_HUNT;
        end
      end
      default: next_state = S_HUNT;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      state    <= S_HUNT;
      shreg    <= '0;
      bitcnt   <= 3'h0;
      sh       <= '0;
      remain   <= 8'h00;
      crc_ok   <= 1'b0;
      rx_flush <= 1'b0;
    end else begin
      state    <= next_state;
      shreg    <= next_shreg;
      bitcnt   <= next_bitcnt;
      sh       <= next_sh;
      remain   <= next_remain;
      crc_ok   <= next_crc_ok;
      rx_flush <= next_flush;
    end
  end

  checksum_serial u_checksum (
    .core_clk   (core_clk),
    .rst_core_n (rst_core_n),
    .clear      (crc_clear),
    .bit_en     (bit_take && in_data_state),
    .bit_in     (rx_bit),
    .next_zero  (crc_zero)
  );

  two_entry_buffer #(.WIDTH(8), .DEPTH(2)) u_buffer (
    .core_clk   (core_clk),
    .rst_core_n (rst_core_n),
    .in_valid   (buf_in_valid),
    .in_ready   (buf_in_ready),
    .in_data    (buf_in_data),
    .out_valid  (fifo_valid),
    .out_ready  (fifo_ready),
    .out_data   (fifo_data)
  );

  // ==========================================
  // Serial pins and synthesizer word
  logic [1:0]  next_pins;
  logic [23:0] next_synth;

  always_comb begin
    case (path)
      PATH_SYNC:  next_pins = {rx_bit_valid, rx_bit};
      PATH_ASYNC: next_pins = {1'b0, rx_bit};
      default:    next_pins = 2'h0;
    endcase
    next_synth = base_freq + 24'(slot * rf_slot_index_spacing);
    if (rx_mode) begin
      next_synth = next_synth - (24'(if_ctl[4:0]) << IF_SHIFT);
    end
  end

  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      general_output_pins <= 2'h0;
      synth_word          <= 24'h000000;
      mixer_if_code       <= 5'h00;
    end else begin
      general_output_pins <= next_pins;
      synth_word          <= next_synth;
      mixer_if_code       <= if_ctl[4:0];
    end
  end

  // ==========================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_core_n);

  sequence s_marker_seen;
    state == S_HUNT && path == PATH_FIFO && bit_take && {shreg, rx_bit} == {mark_hi, mark_lo};
  endsequence
  sequence s_trailer_out;
    buf_in_valid && buf_in_data == rssi ##1 state == S_ST2;
  endsequence

  a_marker_hit: assert property (s_marker_seen |=> state != S_HUNT)
    else $error("marker not taken");
  a_fixed_len: assert property (s_marker_seen and size == LEN_FIXED |=> remain == $past(limit))
    else $error("fixed length not loaded from limit");
  a_var_start: assert property (s_marker_seen and size == LEN_VAR |=> state == S_LEN)
    else $error("variable mode skipped length byte");
  a_len_limit: assert property (state == S_LEN && byte_done && byte_val > limit
    |=> rx_flush && state == S_HUNT) else $error("oversize packet kept");
  a_bad_discard: assert property (state == S_CRC && byte_done && remain == 8'h01
    && !crc_zero && discard |=> rx_flush && state == S_HUNT) else $error("bad packet not flushed");
  a_trailer_rssi: assert property (state == S_ST1 && buf_in_ready |-> s_trailer_out)
    else $error("trailer bytes wrong");
  a_addr_drop: assert property (state == S_ADR && byte_done && byte_val != node &&
    (filter == 2'h1 || byte_val != BCAST_LO) && (filter != FLT_B0FF || byte_val != BCAST_HI)
    |=> rx_flush) else $error("foreign address accepted");
  a_async_pin: assert property (path == PATH_ASYNC |=> general_output_pins[0] == $past(rx_bit))
    else $error("async pin does not follow data");
  a_fifo_quiet: assert property (path != PATH_FIFO && state == S_HUNT
    |=> state == S_HUNT && !buf_in_valid) else $error("packet started in serial mode");
  // Skip the edge at which the internal reset lets go, when the word still holds zero
  a_synth_word: assert property (rst_core_n |=> synth_word == $past(base_freq)
    + 24'($past(slot) * $past(rf_slot_index_spacing))
    - ($past(rx_mode) ? {13'h0000, $past(if_ctl[4:0]), 6'h00} : 24'h000000))
    else $error("synthesizer word wrong");
endmodule

// *** tb/rx_fifo_sink.sv ***
`timescale 1ns/1ns
// ==========================================
// Receive FIFO behind the stream; slow mode takes one byte in four cycles
module rx_fifo_sink (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Byte stream
  input  wire logic [7:0] fifo_data,
  input  wire logic       fifo_valid,
  output logic            fifo_ready,
  input  wire logic       rx_flush,
  // Pacing
  input  wire logic       slow
);
  logic [1:0] ph;
  logic [7:0] q[$];
  int         flush_cnt = 0;

  assign fifo_ready = !slow || ph == 2'h3;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph <= 2'h0;
    end else begin
      ph <= ph + 2'h1;
      if (rx_flush) begin
        q.delete();
        flush_cnt++;
      end else if (fifo_valid && fifo_ready) begin
        q.push_back(fifo_data);
      end
    end
  end
endmodule

// *** tb/rx_packet_handler_tb.sv ***
`timescale 1ns/1ns
module rx_packet_handler_tb;
  import rx_framer_pkg::*;
  logic        core_clk, rst_n, reg_wr, reg_rd, rx_bit, rx_bit_valid, rx_mode, slow;
  logic [5:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, rssi, fifo_data, d;
  logic [6:0]  link_quality;
  logic        rx_bit_ready, fifo_valid, fifo_ready, rx_flush;
  logic [1:0]  general_output_pins, path;
  logic [23:0] base_freq, synth_word;
  logic [15:0] rf_slot_index_spacing;
  logic [4:0]  mixer_if_code;
  int          bad_count = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          f0;
  logic [5:0]  ra[9] = '{6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h0a, 6'h0b, 6'h3f};
  logic [7:0]  rv[9] = '{8'hd3, 8'h91, 8'hff, 8'h04, 8'h45, 8'h00, 8'h00, 8'h0f, 8'h00};
  logic [1:0]  fm[7] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
  logic [7:0]  fa[7] = '{8'h77, 8'h00, 8'hff, 8'h00, 8'hff, 8'h00, 8'hff};
  logic        fk[7] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};

  rx_packet_handler dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid), .rx_bit_ready(rx_bit_ready),
    .rssi(rssi), .link_quality(link_quality), .fifo_data(fifo_data),
    .fifo_valid(fifo_valid), .fifo_ready(fifo_ready), .rx_flush(rx_flush),
    .general_output_pins(general_output_pins), .rx_mode(rx_mode), .base_freq(base_freq),
    .rf_slot_index_spacing(rf_slot_index_spacing), .synth_word(synth_word), .mixer_if_code(mixer_if_code));

  rx_fifo_sink sink (.core_clk(core_clk), .rst_n(rst_n), .fifo_data(fifo_data),
    .fifo_valid(fifo_valid), .fifo_ready(fifo_ready), .rx_flush(rx_flush), .slow(slow));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      test_done();
    end
  end

  // ==========================================
  // Checks and bus tasks
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_q(input logic [7:0] e[$]);
    chk(24'(sink.q.size()), 24'(e.size()));
    foreach (e[i]) chk({16'h0, sink.q[i]}, {16'h0, e[i]});
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] v);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    v = reg_rdata;
  endtask

  // Pin 0 follows the bit one cycle late in the serial paths, pin 1 is high in the sync path only; both stay low otherwise
  function automatic logic [1:0] ep(input logic b);
    case (path)
      2'h1: ep = {1'b1, b};
      2'h3: ep = {1'b0, b};
      default: ep = 2'h0;
    endcase
  endfunction

  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      rx_bit = b[i];
      rx_bit_valid = 1'b1;
      while (rx_bit_ready !== 1'b1) @(negedge core_clk);
      @(negedge core_clk);
      chk({22'h0, general_output_pins}, {22'h0, ep(b[i])});
    end
  endtask

  // Preamble, marker, bytes, then a checksum that leaves a zero remainder unless bad flips its last bit
  task automatic send_pkt(input logic [7:0] p[$], input logic bad);
    logic [15:0] c;
    c = 16'hffff;
    foreach (p[k])
      for (int i = 7; i >= 0; i--)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ p[k][i]) ? 16'h8005 : 16'h0000);
    c = c ^ {15'h0, bad};
    sink.q.delete();
    @(negedge core_clk);
    send_byte(8'h55);
    send_byte(8'h12);
    send_byte(8'h34);
    foreach (p[k]) send_byte(p[k]);
    send_byte(c[15:8]);
    send_byte(c[7:0]);
    rx_bit_valid = 1'b0;
    repeat (60) @(negedge core_clk);
  endtask

  // ==========================================
  // Test sequence
  initial begin
    rst_n = 1'b0; reg_addr = 6'h0; reg_wr = 1'b0; reg_rd = 1'b0; reg_wdata = 8'h0;
    rx_bit = 1'b0; rx_bit_valid = 1'b0; rssi = 8'h37; link_quality = 7'h15; slow = 1'b0;
    rx_mode = 1'b0; base_freq = 24'h100000; rf_slot_index_spacing = 16'h1000; path = 2'h0;
    repeat (10) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    for (int i = 0; i < 9; i++) begin
      rd(ra[i], d);
      chk({16'h0, d}, {16'h0, rv[i]});
    end
    wr(OFF_CTRL_A, 8'hff);
    rd(OFF_CTRL_A, d);
    chk({16'h0, d}, 24'h0000ef);
    wr(OFF_IF, 8'hff);
    rd(OFF_IF, d);
    chk({16'h0, d}, 24'h00003f);
    $display("test registers done");
    wr(OFF_MARK_HI, 8'h12);
    wr(OFF_MARK_LO, 8'h34);
    wr(OFF_NODE, 8'h5a);
    wr(OFF_LIMIT, 8'h03);
    wr(OFF_CTRL_A, 8'h05);
    wr(OFF_CTRL_B, 8'h44);
    slow = 1'b1;
    send_pkt({8'h5a, 8'ha1, 8'hb2}, 1'b0);
    chk_q({8'h5a, 8'ha1, 8'hb2, 8'h37, 8'h95});
    slow = 1'b0;
    $display("test fixed length done");
    wr(OFF_LIMIT, 8'h08);
    wr(OFF_CTRL_B, 8'h45);
    send_pkt({8'h03, 8'h5a, 8'hc3, 8'hd4}, 1'b0);
    chk_q({8'h03, 8'h5a, 8'hc3, 8'hd4, 8'h37, 8'h95});
    f0 = sink.flush_cnt;
    send_pkt({8'h09, 8'h5a}, 1'b0);
    chk(24'(sink.flush_cnt), 24'(f0 + 1));
    $display("test variable length done");
    for (int i = 0; i < 7; i++) begin
      wr(OFF_CTRL_A, {6'h01, fm[i]});
      f0 = sink.flush_cnt;
      send_pkt({8'h02, fa[i], 8'h11}, 1'b0);
      if (fk[i])
        chk_q({8'h02, fa[i], 8'h11, 8'h37, 8'h95});
      else
        chk(24'(sink.flush_cnt), 24'(f0 + 1));
    end
    $display("test address filter done");
    wr(OFF_CTRL_A, 8'h0d);
    f0 = sink.flush_cnt;
    send_pkt({8'h02, 8'h5a, 8'h11}, 1'b1);
    chk(24'(sink.flush_cnt), 24'(f0 + 1));
    wr(OFF_CTRL_A, 8'h05);
    send_pkt({8'h02, 8'h5a, 8'h11}, 1'b1);
    chk_q({8'h02, 8'h5a, 8'h11, 8'h37, 8'h15});
    chk(24'(sink.flush_cnt), 24'(f0 + 1));
    $display("test checksum done");
    for (int i = 0; i < 2; i++) begin
      path = i ? 2'h3 : 2'h1;
      wr(OFF_CTRL_B, {2'h1, path, 4'h5});
      send_pkt({8'h02, 8'ha5, 8'h3c}, 1'b0);
      chk(24'(sink.q.size()), 24'h0);
    end
    path = 2'h0;
    wr(OFF_CTRL_B, 8'h45);
    $display("test serial paths done");
    // Infinite length never ends a packet; a reset in mid-run brings CTRL_B back to 0x45
    wr(OFF_CTRL_A, 8'h00);
    wr(OFF_CTRL_B, 8'h46);
    f0 = sink.flush_cnt;
    send_pkt({8'hc3, 8'hd4}, 1'b0);
    chk(24'(sink.q.size()), 24'h000004);
    chk({16'h0, sink.q[1]}, 24'h0000d4);
    chk(24'(sink.flush_cnt), 24'(f0));
    rst_n = 1'b0;
    repeat (3) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    rd(OFF_CTRL_B, d);
    chk({16'h0, d}, 24'h000045);
    $display("test infinite length done");
    wr(OFF_SLOT, 8'h03);
    wr(OFF_IF, 8'h0a);
    rx_mode = 1'b1;
    repeat (3) @(negedge core_clk);
    chk(synth_word, 24'h102d80);
    chk({19'h0, mixer_if_code}, 24'h00000a);
    rx_mode = 1'b0;
    repeat (3) @(negedge core_clk);
    chk(synth_word, 24'h103000);
    $display("test synthesizer done");
    test_done();
  end
endmodule
